/* design/adcsel_ctrl.v */
// Purpose: input routing, pin override and conversion sequencing of a 12-bit SAR converter
// Assumes: software keeps source code 111 unused and parks the channel before internal sources
// Notes:   the analog result arrives as a 12-bit code from the converter core at end of conversion
//          a start rise mid-run restarts the conversion; power loss aborts with no request
`timescale 1ns/1ps
`default_nettype none
`include "adcsel_regs.vh"

// What this block does
// - analog pin selection disables other pin functions
// - pull-high dropped on analog-selected pins
// - analog selection overrides port direction control
// - codes 000,101,110 route external channel
// - channel 0-7 connects pin; 8-15 floats
// - codes 001-100 pick internal signals
// - normal conversion: 4 sample, 12 convert
// - temperature source: 46 sample, 12 convert
// - converter clock is system clock over 2^n
// - start rise resets, fall launches conversion
// - busy high during conversion, result after
// - conversion completes without processor help
// - alignment bit picks result byte layout
// - power enable clear powers converter down
// - result is 12-bit unsigned, step Vref/4096
// - reference codes: 00 ext, 01/11 supply, 10 temp
module adcsel_ctrl #(
    parameter NPIN = 8
) (
    input  wire            clock_i,
    input  wire            sys_rst_i,
    input  wire            converter_power_en_i,
    input  wire [2:0]      input_source_sel_i,
    input  wire [3:0]      ext_channel_sel_i,
    input  wire [2:0]      conv_clock_div_sel_i,
    input  wire [1:0]      reference_sel_i,
    input  wire            result_align_sel_i,
    input  wire            start_i,
    input  wire            global_irq_en_i,
    input  wire            conv_irq_en_i,
    input  wire            conv_irq_clear_i,
    input  wire [NPIN-1:0] pin_function_select_i,
    input  wire [NPIN-1:0] port_dir_in_i,
    input  wire [NPIN-1:0] pull_high_en_i,
    input  wire [11:0]     sar_code_i,
    output reg  [NPIN-1:0] analog_pin_n_o,
    output reg  [NPIN-1:0] pin_digital_en_o,
    output reg  [NPIN-1:0] pin_input_dir_o,
    output reg  [NPIN-1:0] pull_high_on_o,
    output reg  [NPIN-1:0] ext_channel_connect_o,
    output reg  [3:0]      internal_source_connect_o,
    output reg  [2:0]      reference_connect_o,
    output reg             converter_power_o,
    output reg             sar_reset_o,
    output reg             sampling_o,
    output reg             converting_o,
    output reg             conversion_busy_flag_o,
    output reg  [7:0]      result_high_byte_o,
    output reg  [7:0]      result_low_byte_o,
    output reg             conv_irq_request_o,
    output reg             conv_irq_o
);
    // sequencer states
    localparam ST_IDLE   = 2'b00;
    localparam ST_ARMED  = 2'b01;
    localparam ST_SAMPLE = 2'b10;
    localparam ST_CONV   = 2'b11;

    // sequencer registers and their next values
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [5:0]  cnt_ff;
    reg  [5:0]  nxt_cnt;
    reg         start_ff;
    reg  [2:0]  div_ff;
    reg  [2:0]  nxt_div;
    reg  [11:0] code_ff;
    reg         done;
    reg         nxt_irq_req;
    reg  [3:0]  nxt_int;
    reg  [NPIN-1:0] nxt_ext;
    reg  [2:0]  nxt_ref;
    wire        tick;
    wire        start_rise;
    wire        start_fall;
    wire        ext_src;
    wire        run;

    // start edges from one registered copy of the pin
    // start_ff resets low, the idle level, so reset makes no false edge
    assign start_rise = start_i && !start_ff;
    assign start_fall = !start_i && start_ff;
    assign run        = (state_ff == ST_SAMPLE) || (state_ff == ST_CONV);
    assign ext_src    = (input_source_sel_i == `ADCSEL_SRC_EXT0) ||
                        (input_source_sel_i == `ADCSEL_SRC_EXT5) ||
                        (input_source_sel_i == `ADCSEL_SRC_EXT6);

    // converter clock ticks; the divider code is latched at launch so
    // a change made mid-run cannot stretch or cut the phases
    adcsel_clkdiv #(
        .DIV_W (3)
    ) u_clkdiv (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (run),
        .div_sel_i (div_ff),
        .tick_o    (tick)
    );

    // per-pin function override; analog selection wins over digital setup
    // registered so every pin output leaves from a flip-flop
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_pin
            always @(posedge clock_i) begin
                if (sys_rst_i) begin
                    analog_pin_n_o[g]   <= 1'b0;
                    pin_digital_en_o[g] <= 1'b1;
                    pin_input_dir_o[g]  <= 1'b1;
                    pull_high_on_o[g]   <= 1'b0;
                end else begin
                    analog_pin_n_o[g]   <= pin_function_select_i[g];
                    pin_digital_en_o[g] <= !pin_function_select_i[g];
                    pull_high_on_o[g]   <= pull_high_en_i[g] && !pin_function_select_i[g];
                    pin_input_dir_o[g]  <= port_dir_in_i[g] || pin_function_select_i[g];
                end
            end
        end
    endgenerate

    // analog mux decode; codes 8-15 reach no pin, so the input floats
    // source 111 falls to the default and closes no switch at all
    always @* begin
        nxt_ext = {NPIN{1'b0}};
        if (ext_src && !ext_channel_sel_i[3] && (ext_channel_sel_i[2:0] < NPIN)) begin
            nxt_ext[ext_channel_sel_i[2:0]] = 1'b1;
        end
        case (input_source_sel_i)
            `ADCSEL_SRC_BANDGAP: nxt_int = `ADCSEL_INT_BANDGAP;
            `ADCSEL_SRC_TEMP:    nxt_int = `ADCSEL_INT_TEMP;
            `ADCSEL_SRC_OPOUT:   nxt_int = `ADCSEL_INT_OPOUT;
            `ADCSEL_SRC_OPPOS:   nxt_int = `ADCSEL_INT_OPPOS;
            default:             nxt_int = `ADCSEL_INT_NONE;  // forbidden 111 connects nothing
        endcase
        case (reference_sel_i)
            `ADCSEL_REF_EXT:      nxt_ref = `ADCSEL_REFSEL_EXT;
            `ADCSEL_REF_TEMP:     nxt_ref = `ADCSEL_REFSEL_TEMP;
            default:              nxt_ref = `ADCSEL_REFSEL_SUPPLY;
        endcase
    end

    // mux switches opened while powered down so nothing loads the inputs
    // reference switch stays live so it settles before the next start
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            ext_channel_connect_o     <= {NPIN{1'b0}};
            internal_source_connect_o <= `ADCSEL_INT_NONE;
            reference_connect_o       <= `ADCSEL_REFSEL_SUPPLY;
            converter_power_o         <= 1'b0;
        end else begin
            converter_power_o         <= converter_power_en_i;
            ext_channel_connect_o     <= converter_power_en_i ? nxt_ext : {NPIN{1'b0}};
            internal_source_connect_o <= converter_power_en_i ? nxt_int : `ADCSEL_INT_NONE;
            reference_connect_o       <= nxt_ref;
        end
    end

    // sequencer: rise resets, fall launches, counts run on converter ticks
    always @* begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_div      = div_ff;
        done         = 1'b0;
        case (state_ff)
            // only a rise leaves idle; a lone fall is ignored
            ST_IDLE: begin
                if (start_rise) begin
                    nxt_state = ST_ARMED;
                end
            end
            // source class and divider are frozen at launch
            ST_ARMED: begin
                if (start_fall) begin
                    nxt_state    = ST_SAMPLE;
                    nxt_div      = conv_clock_div_sel_i;
                    nxt_cnt      = (input_source_sel_i == `ADCSEL_SRC_TEMP) ?
                                   `ADCSEL_SAMPLE_TEMP : `ADCSEL_SAMPLE_STD;
                end
            end
            // sampling: load the convert count after the last sample tick
            ST_SAMPLE: begin
                if (tick) begin
                    nxt_cnt = cnt_ff - 6'h01;
                    if (cnt_ff == 6'h01) begin
                        nxt_state = ST_CONV;
                        nxt_cnt   = `ADCSEL_CONVERT;
                    end
                end
            end
            // conversion: the last tick pulses done for one cycle
            ST_CONV: begin
                if (tick) begin
                    nxt_cnt = cnt_ff - 6'h01;
                    if (cnt_ff == 6'h01) begin
                        nxt_state = ST_IDLE;
                        done      = 1'b1;
                    end
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        // a new rise restarts mid-conversion; power loss aborts outright
        // neither path pulses done, so no request and no new result
        if (start_rise && state_ff != ST_IDLE) begin
            nxt_state = ST_ARMED;
            done      = 1'b0;
        end
        if (!converter_power_en_i) begin
            nxt_state = ST_IDLE;
            done      = 1'b0;
        end
    end

    // sequencer registers; divider code captured with the launch
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_ff    <= ST_IDLE;
            cnt_ff      <= 6'h00;
            start_ff    <= 1'b0;
            div_ff      <= 3'h0;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            start_ff    <= start_i;
            div_ff      <= nxt_div;
        end
    end

    // phase and busy indicators, registered from next state
    // taken from next state so busy rises on the launch edge itself
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            sar_reset_o            <= 1'b0;
            sampling_o             <= 1'b0;
            converting_o           <= 1'b0;
            conversion_busy_flag_o <= 1'b0;
        end else begin
            sar_reset_o            <= (nxt_state == ST_ARMED);
            sampling_o             <= (nxt_state == ST_SAMPLE);
            converting_o           <= (nxt_state == ST_CONV);
            conversion_busy_flag_o <= (nxt_state == ST_SAMPLE) || (nxt_state == ST_CONV);
        end
    end

    // result capture; bytes hold the last result until the next completion
    // aborts raise no done, so an aborted run leaves the old result
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            code_ff <= 12'h000;
        end else if (done) begin
            code_ff <= sar_code_i;
        end
    end

    // layout follows the align bit live, so software may flip it after the fact
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            result_high_byte_o <= 8'h00;
            result_low_byte_o  <= 8'h00;
        end else if (result_align_sel_i) begin
            result_high_byte_o <= {4'h0, code_ff[`ADCSEL_RESULT_MSB:8]};
            result_low_byte_o  <= code_ff[7:0];
        end else begin
            result_high_byte_o <= code_ff[`ADCSEL_RESULT_MSB:4];
            result_low_byte_o  <= {code_ff[3:0], 4'h0};
        end
    end

    // request flag next value: set wins over a clear in the same cycle
    // so a completion landing on a software clear is never lost
    always @* begin
        nxt_irq_req = done || (conv_irq_request_o && !conv_irq_clear_i);
    end

    // flag and gated interrupt line both leave straight from flops
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            conv_irq_request_o <= 1'b0;
            conv_irq_o         <= 1'b0;
        end else begin
            conv_irq_request_o <= nxt_irq_req;
            conv_irq_o         <= nxt_irq_req && global_irq_en_i && conv_irq_en_i;
        end
    end
endmodule // adcsel_ctrl
`default_nettype wire

/* design/adcsel_regs.vh */
// Purpose: constants for the converter input select and conversion control
// Assumes: included by adcsel design files only
// Notes:   codes are field encodings; counts are in converter clock periods
`ifndef ADCSEL_REGS_VH
`define ADCSEL_REGS_VH

`define ADCSEL_SRC_EXT0      3'h0
`define ADCSEL_SRC_BANDGAP   3'h1
`define ADCSEL_SRC_TEMP      3'h2
`define ADCSEL_SRC_OPOUT     3'h3
`define ADCSEL_SRC_OPPOS     3'h4
`define ADCSEL_SRC_EXT5      3'h5
`define ADCSEL_SRC_EXT6      3'h6
`define ADCSEL_SRC_FORBID    3'h7

`define ADCSEL_INT_NONE      4'h0
`define ADCSEL_INT_BANDGAP   4'h1
`define ADCSEL_INT_TEMP      4'h2
`define ADCSEL_INT_OPOUT     4'h4
`define ADCSEL_INT_OPPOS     4'h8

`define ADCSEL_REF_EXT       2'h0
`define ADCSEL_REF_SUPPLY_A  2'h1
`define ADCSEL_REF_TEMP      2'h2
`define ADCSEL_REF_SUPPLY_B  2'h3
`define ADCSEL_REFSEL_EXT    3'h1
`define ADCSEL_REFSEL_SUPPLY 3'h2
`define ADCSEL_REFSEL_TEMP   3'h4

`define ADCSEL_SAMPLE_STD    6'h04
`define ADCSEL_SAMPLE_TEMP   6'h2E
`define ADCSEL_CONVERT       6'h0C
`define ADCSEL_RESULT_MSB    11

`endif

/* design/adcsel_clkdiv.v */
// Purpose: converter clock tick generator, system clock divided by 2^n
// Assumes: div_sel_i steady while a conversion runs
// Notes:   tick_o is a one-cycle pulse once per converter clock period
`timescale 1ns/1ps
`default_nettype none
module adcsel_clkdiv #(
    parameter DIV_W = 3
) (
    input  wire             clock_i,
    input  wire             sys_rst_i,
    input  wire             run_i,
    input  wire [DIV_W-1:0] div_sel_i,
    output wire             tick_o
);
    localparam CNT_W = (1 << DIV_W) - 1;

    reg  [CNT_W-1:0] cnt_ff;
    wire [CNT_W-1:0] mask;

    // mask keeps the low n bits; wrap of those bits marks one period
    assign mask   = ~({CNT_W{1'b1}} << div_sel_i);
    assign tick_o = run_i && ((cnt_ff & mask) == mask);

    // counter held clear when idle so each conversion starts phase-aligned
    always @(posedge clock_i) begin
        if (sys_rst_i || !run_i) begin
            cnt_ff <= {CNT_W{1'b0}};
        end else begin
            cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // adcsel_clkdiv
`default_nettype wire

/* sim/adcsel_props_properties.sv */
// Purpose: port checks of adcsel_ctrl
// Assumes: span checks only at the undivided converter clock
// Notes:   power-down or restart aborts switch the span check off
`timescale 1ns/1ps
`default_nettype none
module adcsel_props #(
    parameter NPIN = 8
) (
    input wire logic            clock_i,
    input wire logic            sys_rst_i,
    input wire logic            converter_power_en_i,
    input wire logic [2:0]      input_source_sel_i,
    input wire logic [3:0]      ext_channel_sel_i,
    input wire logic [2:0]      conv_clock_div_sel_i,
    input wire logic [1:0]      reference_sel_i,
    input wire logic            result_align_sel_i,
    input wire logic            start_i,
    input wire logic [NPIN-1:0] pin_function_select_i,
    input wire logic [NPIN-1:0] port_dir_in_i,
    input wire logic [NPIN-1:0] pull_high_en_i,
    input wire logic [11:0]     sar_code_i,
    input wire logic [NPIN-1:0] pin_digital_en_o,
    input wire logic [NPIN-1:0] pin_input_dir_o,
    input wire logic [NPIN-1:0] pull_high_on_o,
    input wire logic [NPIN-1:0] ext_channel_connect_o,
    input wire logic [2:0]      reference_connect_o,
    input wire logic            converting_o,
    input wire logic            conversion_busy_flag_o,
    input wire logic [7:0]      result_high_byte_o,
    input wire logic [7:0]      result_low_byte_o,
    input wire logic            conv_irq_request_o
);
    // one clock domain, one reset
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // pin overrides lag the selection by one edge
    property p_pin_func; !$past(sys_rst_i) |-> pin_digital_en_o == ~$past(pin_function_select_i); endproperty
    a_pin_func: assert property (p_pin_func) else $error("pin function left on");
    property p_pull; !$past(sys_rst_i) |-> pull_high_on_o == ($past(pull_high_en_i) & ~$past(pin_function_select_i)); endproperty
    a_pull: assert property (p_pull) else $error("pull-high left on");
    property p_dir; !$past(sys_rst_i) |-> pin_input_dir_o == ($past(port_dir_in_i) | $past(pin_function_select_i)); endproperty
    a_dir: assert property (p_dir) else $error("direction not overridden");
    property p_ext; !$past(sys_rst_i) && $past(converter_power_en_i) && !$past(ext_channel_sel_i[3])
        && $past(input_source_sel_i) inside {3'h0, 3'h5, 3'h6}
        |-> ext_channel_connect_o == NPIN'(1) << $past(ext_channel_sel_i[2:0]); endproperty
    a_ext: assert property (p_ext) else $error("external switch wrong");
    property p_ref; !$past(sys_rst_i) |-> reference_connect_o == ($past(reference_sel_i) == 2'h2 ? 3'h4
        : ($past(reference_sel_i) == 2'h0 ? 3'h1 : 3'h2)); endproperty
    a_ref: assert property (p_ref) else $error("reference switch wrong");
    // aborts end busy early, so they switch the span off
    property p_busy_span; disable iff (sys_rst_i || start_i || !converter_power_en_i)
        $rose(conversion_busy_flag_o) && conv_clock_div_sel_i == 3'h0 && input_source_sel_i != 3'h2
        |-> conversion_busy_flag_o[*8] ##1 conversion_busy_flag_o[*8] ##[1:2] !conversion_busy_flag_o; endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy span not 16");
    property p_done; $fell(conversion_busy_flag_o) && $past(converting_o) && $past(converter_power_en_i)
        && !$past(start_i) |-> conv_irq_request_o; endproperty
    a_done: assert property (p_done) else $error("completion without request");
    // bytes show the code taken two edges back, in the layout of the edge before
    property p_result; $rose(conv_irq_request_o) |=> ($past(result_align_sel_i)
        ? {result_high_byte_o, result_low_byte_o} == {4'h0, $past(sar_code_i, 2)}
        : {result_high_byte_o, result_low_byte_o} == {$past(sar_code_i, 2), 4'h0}); endproperty
    a_result: assert property (p_result) else $error("result layout wrong");
endmodule // adcsel_props
bind adcsel_ctrl adcsel_props #(
    .NPIN (NPIN)
) i_props (
    .clock_i                (clock_i),
    .sys_rst_i              (sys_rst_i),
    .converter_power_en_i   (converter_power_en_i),
    .input_source_sel_i     (input_source_sel_i),
    .ext_channel_sel_i      (ext_channel_sel_i),
    .conv_clock_div_sel_i   (conv_clock_div_sel_i),
    .reference_sel_i        (reference_sel_i),
    .result_align_sel_i     (result_align_sel_i),
    .start_i                (start_i),
    .pin_function_select_i  (pin_function_select_i),
    .port_dir_in_i          (port_dir_in_i),
    .pull_high_en_i         (pull_high_en_i),
    .sar_code_i             (sar_code_i),
    .pin_digital_en_o       (pin_digital_en_o),
    .pin_input_dir_o        (pin_input_dir_o),
    .pull_high_on_o         (pull_high_on_o),
    .ext_channel_connect_o  (ext_channel_connect_o),
    .reference_connect_o    (reference_connect_o),
    .converting_o           (converting_o),
    .conversion_busy_flag_o (conversion_busy_flag_o),
    .result_high_byte_o     (result_high_byte_o),
    .result_low_byte_o      (result_low_byte_o),
    .conv_irq_request_o     (conv_irq_request_o)
);
`default_nettype wire

/* sim/adcsel_analog_model.sv */
// Purpose: analog sources behind the input switches
// Assumes: at most one switch closed
// Notes:   an open input wanders each cycle
`timescale 1ns/1ps
`default_nettype none
module adcsel_analog_model (
    input  wire logic        clock_i,
    input  wire logic [7:0]  ext_channel_connect_o,
    input  wire logic [3:0]  internal_source_connect_o,
    output var  logic [11:0] sar_code_i
);
    logic [11:0] float_ff = 12'h5A5;
    integer      k;
    // floating node never holds a value
    always @(posedge clock_i) float_ff <= ~float_ff + 12'h001;
    // a closed switch yields a code naming its source
    always @* begin
        sar_code_i = float_ff;
        for (k = 0; k < 8; k = k + 1) if (ext_channel_connect_o[k]) sar_code_i = 12'hA50 + k[11:0];
        for (k = 0; k < 4; k = k + 1) if (internal_source_connect_o[k]) sar_code_i = 12'h3C0 + k[11:0];
    end
endmodule // adcsel_analog_model
`default_nettype wire

/* sim/test_adc_input_select_conversion_control.sv */
// Purpose: directed bench for adcsel_ctrl
// Assumes: analog model supplies the core code
// Notes:   floating inputs are never converted
`timescale 1ns/1ps
`default_nettype none
module test_adc_input_select_conversion_control;
    logic        clock_i = 1'b0, sys_rst_i = 1'b1, converter_power_en_i = 1'b1, result_align_sel_i = 1'b0;
    logic        start_i = 1'b0, global_irq_en_i = 1'b1, conv_irq_en_i = 1'b1, conv_irq_clear_i = 1'b0;
    logic [2:0]  input_source_sel_i = 3'h0, conv_clock_div_sel_i = 3'h0;
    logic [1:0]  reference_sel_i = 2'h0;
    logic [3:0]  ext_channel_sel_i = 4'h8;
    logic [7:0]  pin_function_select_i = 8'h0F, port_dir_in_i = 8'h30, pull_high_en_i = 8'hFF;
    wire  [11:0] sar_code_i;
    wire  [7:0]  analog_pin_n_o, pin_digital_en_o, pin_input_dir_o, pull_high_on_o, ext_channel_connect_o;
    wire  [7:0]  result_high_byte_o, result_low_byte_o;
    wire  [3:0]  internal_source_connect_o;
    wire  [2:0]  reference_connect_o;
    wire         converter_power_o, sar_reset_o, sampling_o, converting_o, conversion_busy_flag_o;
    wire         conv_irq_request_o, conv_irq_o;
    integer      n_mismatch = 0, samples_checked = 0, i;

    adcsel_ctrl i_dut (.*);
    adcsel_analog_model i_src (.*);

    // 250 MHz system clock
    always #2 clock_i = ~clock_i;

    task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (e !== g) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask

    // channel parked before source changes, then one start pulse
    task conv(input [2:0] s, input [3:0] c, input [2:0] d, input a, input [11:0] code);
        integer n, e, m;
        begin
            @(negedge clock_i);
            ext_channel_sel_i = c;
            conv_clock_div_sel_i = d;
            result_align_sel_i = a;
            @(negedge clock_i);
            input_source_sel_i = s;
            start_i = 1'b1;
            @(negedge clock_i);
            e = (s >= 3'h1 && s <= 3'h4) ? 256 << (s - 3'h1) : (c < 4'h8 ? 1 << c : 0);
            chk("switch", e[15:0], {4'h0, internal_source_connect_o, ext_channel_connect_o});
            chk("armed", 16'h0001, {15'h0, sar_reset_o});
            start_i = 1'b0;
            for (n = 0; n < 4 && conversion_busy_flag_o !== 1'b1; n = n + 1) @(negedge clock_i);
            chk("phase", 16'h0002, {14'h0, sampling_o, converting_o});
            m = 0;
            for (n = 0; n < 9000 && conversion_busy_flag_o === 1'b1; n = n + 1) begin
                if (sampling_o === 1'b1) m = m + 1;
                @(negedge clock_i);
            end
            e = (s == 3'h2 ? 46 : 4) << d;
            chk("sample", 16'h0001, {15'h0, m >= e && m <= e + 1});
            e = (s == 3'h2 ? 58 : 16) << d;
            chk("busy_len", 16'h0001, {15'h0, n >= e && n <= e + 1});
            e = {14'h0, 1'b1, global_irq_en_i && conv_irq_en_i};
            chk("irq", e[15:0], {14'h0, conv_irq_request_o, conv_irq_o});
            chk("idle_ph", 16'h0000, {14'h0, sampling_o, converting_o});
            @(negedge clock_i);
            chk("result", a ? {4'h0, code} : {code, 4'h0}, {result_high_byte_o, result_low_byte_o});
            conv_irq_clear_i = 1'b1;
            @(negedge clock_i);
            conv_irq_clear_i = 1'b0;
            chk("cleared", 16'h0000, {15'h0, conv_irq_request_o});
        end
    endtask

    task close_out;
        begin
            if (n_mismatch == 0 && samples_checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // hang guard, far beyond the expected run of just over a thousand ns
    initial begin
        #40000;
        n_mismatch = n_mismatch + 1;
        close_out;
    end

    // main sequence
    initial begin
        repeat (5) @(negedge clock_i);
        chk("rst", 16'hFF02, {pin_digital_en_o, 5'h0, reference_connect_o});
        repeat (5) @(negedge clock_i);
        sys_rst_i = 1'b0;
        @(negedge clock_i);
        chk("pins", 16'hF03F, {pin_digital_en_o, pin_input_dir_o});
        chk("pull", 16'h00F0, {8'h0, pull_high_on_o});
        chk("analog", 16'h010F, {7'h0, converter_power_o, analog_pin_n_o});
        for (i = 0; i < 4; i = i + 1) begin
            reference_sel_i = i[1:0];
            @(negedge clock_i);
            chk("ref", i == 2 ? 16'h0004 : (i == 0 ? 16'h0001 : 16'h0002), {13'h0, reference_connect_o});
        end
        conv(3'h0, 4'h3, 3'h0, 1'b1, 12'hA53);
        conv(3'h5, 4'h7, 3'h1, 1'b0, 12'hA57);
        conv(3'h6, 4'h0, 3'h2, 1'b1, 12'hA50);
        conv(3'h1, 4'h8, 3'h0, 1'b0, 12'h3C0);
        conv(3'h2, 4'h9, 3'h0, 1'b1, 12'h3C1);
        conv_irq_en_i = 1'b0;
        conv(3'h3, 4'hF, 3'h0, 1'b0, 12'h3C2);
        conv_irq_en_i = 1'b1;
        global_irq_en_i = 1'b0;
        conv(3'h4, 4'hC, 3'h0, 1'b1, 12'h3C3);
        // power dropped mid-conversion: no completion
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
        repeat (6) @(negedge clock_i);
        chk("busy_mid", 16'h0001, {15'h0, conversion_busy_flag_o});
        // a rise mid-run re-arms with no completion, the fall relaunches
        start_i = 1'b1;
        @(negedge clock_i);
        chk("restart", 16'h0002, {13'h0, conversion_busy_flag_o, sar_reset_o, conv_irq_request_o});
        start_i = 1'b0;
        @(negedge clock_i);
        chk("relaunch", 16'h0001, {15'h0, conversion_busy_flag_o});
        converter_power_en_i = 1'b0;
        repeat (3) @(negedge clock_i);
        chk("abort", 16'h0000, {13'h0, conversion_busy_flag_o, conv_irq_request_o, converter_power_o});
        converter_power_en_i = 1'b1;
        close_out;
    end
endmodule // test_adc_input_select_conversion_control
`default_nettype wire
